// ### icu_pkg.sv
// Constants, register map and carrier types of the interrupt and transfer unit.
package icu_pkg;

	// Channel count of the transfer unit and default source counts.
	localparam int NCH       = 8;
	localparam int NSRC_DEF  = 16;
	localparam int NEXT_DEF  = 4;
	localparam int NTRAP_DEF = 4;

	// Register word addresses on the plain register port.
	localparam logic [7:0] ADR_SRC  = 8'h00;
	localparam logic [7:0] ADR_CHN  = 8'h20;
	localparam logic [7:0] ADR_SPTR = 8'h30;
	localparam logic [7:0] ADR_DPTR = 8'h38;
	localparam logic [7:0] ADR_EDGE = 8'h40;
	localparam logic [7:0] ADR_TRAP = 8'h41;
	localparam logic [7:0] ADR_STAT = 8'h42;
	localparam logic [7:0] ADR_MASK = 8'h43;

	// Source control word fields.
	localparam int SC_LVL_LO = 0;
	localparam int SC_EN     = 4;
	localparam int SC_XSEL   = 5;
	localparam int SC_CH_LO  = 6;
	localparam int SC_REQ    = 9;

	// Channel control word fields.
	localparam int CC_CNT_LO = 0;
	localparam int CC_WORD   = 8;
	localparam int CC_CONT   = 9;
	localparam int CC_ISRC   = 10;
	localparam int CC_IDST   = 11;

	// Edge select bits, two per fast external input.
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;

	// Vector bases and reset values.
	localparam logic [7:0]  VEC_TRAP_BASE = 8'h00;
	localparam logic [7:0]  VEC_SRC_BASE  = 8'h10;
	localparam logic [15:0] RST_WORD      = 16'h0000;
	localparam logic [7:0]  RST_BYTE      = 8'h00;
	localparam logic [7:0]  CNT_ONE       = 8'h01;

	// Service handed to the CPU core.
	typedef struct packed {
		logic       valid;
		logic       push;
		logic [7:0] vector;
	} cpu_svc_s;

	// Single move handed to the memory side.
	typedef struct packed {
		logic        valid;
		logic        word;
		logic [15:0] src;
		logic [15:0] dst;
	} xfer_s;

endpackage : icu_pkg

// ### interrupt_and_event_transfer.sv
// Prioritising interrupt controller with an eight channel event transfer unit.
//
// Function
// - Arbitrate all pending enabled sources against each other every machine cycle.
// - Each source selects CPU interrupt or transfer unit service.
// - A winning transfer selection starts a move on its channel.
// - A transfer moves one byte or word, one cycle, no state save.
// - CPU interrupt accepted only if its level exceeds the CPU level.
// - Accepted interrupt pushes machine state and branches to source vector.
// - Eight channels, each with count value and control bits.
// - Channel source and destination pointers live in a RAM region.
// - Each transfer decrements the channel count unless continuous mode.
// - At count zero the request becomes a standard interrupt.
// - Fast external inputs detect rising, falling or both edges.
// - Software trap raises the service named by its trap number.
// - Hardware traps are non-maskable and branch to dedicated vectors.
// - Each hardware trap sets its own bit in the trap flag register.
// - A hardware trap preempts all except an equal or higher trap in service.
// - During trap service, interrupts and transfers are blocked.
// - Locked sequences hold off interrupts, transfers and class A traps.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module interrupt_and_event_transfer #(
	parameter int              NSRC   = icu_pkg::NSRC_DEF,
	parameter int              NEXT   = icu_pkg::NEXT_DEF,
	parameter int              NTRAP  = icu_pkg::NTRAP_DEF,
	parameter logic [NTRAP-1:0] CLASSA = 4'h3
) (
	// Clock and reset.
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	// Register port.
	input  wire logic [7:0]           regAddr,
	input  wire logic [15:0]          regWdata,
	input  wire logic                 regWr,
	input  wire logic                 regRd,
	output logic [15:0]               regRdata,
	// Request sources.
	input  wire logic [NSRC-1:0]      periphReq,
	input  wire logic [NEXT-1:0]      extPin,
	input  wire logic [NTRAP-1:0]     hwTrap,
	input  wire logic                 swTrap,
	input  wire logic [7:0]           swTrapNum,
	// CPU status.
	input  wire logic [3:0]           cpuLevel,
	input  wire logic                 lockSeq,
	input  wire logic                 trapDone,
	// Services.
	output icu_pkg::cpu_svc_s         cpuSvc,
	output icu_pkg::xfer_s            xfer,
	output logic                      irq
);
	localparam int SW = $clog2(NSRC);
	localparam int TW = $clog2(NTRAP);
	if (NSRC > 16 || NSRC <= NEXT || NEXT < 1 || NEXT > 8 ||
			NTRAP < 2 || NTRAP > 8) begin : g_chk
		$error("Unsupported source or trap count.");
	end
	logic [15:0]     srcCtl_r [NSRC];
	logic [NSRC-1:0] reqFlag_r;
	logic [11:0]     chnCtl_r [icu_pkg::NCH];
	logic [15:0]     ptrSrc_r [icu_pkg::NCH];
	logic [15:0]     ptrDst_r [icu_pkg::NCH];
	logic [15:0]     edgeSel_r;
	logic [NEXT-1:0] extPrev_r;
	logic [7:0]      trapFlag_r;
	logic [7:0]      trapPend_r;
	logic            trapBusy_r;
	logic [TW-1:0]   trapCur_r;
	logic            swPend_r;
	logic [7:0]      swNum_r;
	logic [7:0]      status_r;
	logic [7:0]      mask_r;
	logic [NSRC-1:0] srcEvt;
	logic            winFound;
	logic [SW-1:0]   winIdx;
	logic [3:0]      winLvl;
	logic [2:0]      winCh;
	logic [7:0]      winCnt;
	logic            winCont;
	logic            goTrap;
	logic [TW-1:0]   trapIdx;
	logic            swGo;
	logic            blockStd;
	logic            goXfer;
	logic            goInt;
	logic            wrSrc;
	logic            wrChn;
	logic            wrSptr;
	logic            wrDptr;
	logic [15:0]     rdNxt;
	// Register decode for the table areas.
	assign wrSrc  = regWr && regAddr >= icu_pkg::ADR_SRC &&
		regAddr < icu_pkg::ADR_SRC + 8'(NSRC);
	assign wrChn  = regWr && regAddr[7:3] == icu_pkg::ADR_CHN[7:3];
	assign wrSptr = regWr && regAddr[7:3] == icu_pkg::ADR_SPTR[7:3];
	assign wrDptr = regWr && regAddr[7:3] == icu_pkg::ADR_DPTR[7:3];

	always_comb begin
		srcEvt = periphReq;
		for (int i = 0; i < NEXT; i++) begin
			srcEvt[i] = periphReq[i] ||
				(edgeSel_r[2*i+icu_pkg::EDGE_RISE_BIT] && extPin[i] &&
					!extPrev_r[i]) ||
				(edgeSel_r[2*i+icu_pkg::EDGE_FALL_BIT] && !extPin[i] &&
					extPrev_r[i]);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			extPrev_r <= '0;
		end else begin
			extPrev_r <= extPin;
		end
	end

	// arbitrate every cycle.
	// Highest level wins; on equal levels the lower source number wins.
	always_comb begin
		winFound = 1'b0;
		winIdx   = '0;
		winLvl   = 4'h0;
		for (int i = 0; i < NSRC; i++) begin
			if (reqFlag_r[i] && srcCtl_r[i][icu_pkg::SC_EN] &&
					(!winFound || srcCtl_r[i][3:0] > winLvl)) begin
				winFound = 1'b1;
				winIdx   = SW'(i);
				winLvl   = srcCtl_r[i][3:0];
			end
		end
	end

	assign winCh   = srcCtl_r[winIdx][icu_pkg::SC_CH_LO +: 3];
	assign winCnt  = chnCtl_r[winCh][icu_pkg::CC_CNT_LO +: 8];
	assign winCont = chnCtl_r[winCh][icu_pkg::CC_CONT];
	// trap preemption order.
	// A lower trap number is a higher priority; class A waits for locks.
	always_comb begin
		goTrap  = 1'b0;
		trapIdx = '0;
		for (int i = NTRAP - 1; i >= 0; i--) begin
			if (trapPend_r[i] && !(lockSeq && CLASSA[i]) &&
					(!trapBusy_r || TW'(i) < trapCur_r)) begin
				goTrap  = 1'b1;
				trapIdx = TW'(i);
			end
		end
	end

	assign swGo = swPend_r && !goTrap;
	assign blockStd = lockSeq || trapBusy_r || goTrap || swGo;
	// exhausted count falls back to an interrupt.
	assign goXfer = winFound && !blockStd &&
		srcCtl_r[winIdx][icu_pkg::SC_XSEL] && (winCnt != 8'h00 || winCont);
	assign goInt  = winFound && !blockStd && !goXfer && winLvl > cpuLevel;
	// Source control words.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NSRC; i++) begin
				srcCtl_r[i] <= icu_pkg::RST_WORD;
			end
		end else if (wrSrc) begin
			srcCtl_r[regAddr[SW-1:0]] <= regWdata;
		end
	end

	// clear on acceptance.
	// A new event in the acceptance cycle wins, so it is never lost.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reqFlag_r <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (srcEvt[i]) begin
					reqFlag_r[i] <= 1'b1;
				end else if ((goXfer || goInt) && winIdx == SW'(i)) begin
					reqFlag_r[i] <= 1'b0;
				end else if (wrSrc && regAddr[SW-1:0] == SW'(i)) begin
					reqFlag_r[i] <= regWdata[icu_pkg::SC_REQ];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			for (int c = 0; c < icu_pkg::NCH; c++) begin
				chnCtl_r[c] <= 12'h000;
			end
		end else begin
			if (wrChn) begin
				chnCtl_r[regAddr[2:0]] <= regWdata[11:0];
			end
			if (goXfer && !winCont) begin
				chnCtl_r[winCh][icu_pkg::CC_CNT_LO +: 8] <= winCnt - icu_pkg::CNT_ONE;
			end
		end
	end

	// pointers held in the RAM region.
	// The hardware update wins over a software write to the same pointer.
	always_ff @(posedge clk_sys) begin
		if (wrSptr) begin
			ptrSrc_r[regAddr[2:0]] <= regWdata;
		end
		if (wrDptr) begin
			ptrDst_r[regAddr[2:0]] <= regWdata;
		end
		if (goXfer) begin
			if (chnCtl_r[winCh][icu_pkg::CC_ISRC]) begin
				ptrSrc_r[winCh] <= ptrSrc_r[winCh] +
					(chnCtl_r[winCh][icu_pkg::CC_WORD] ? 16'h0002 : 16'h0001);
			end
			if (chnCtl_r[winCh][icu_pkg::CC_IDST]) begin
				ptrDst_r[winCh] <= ptrDst_r[winCh] +
					(chnCtl_r[winCh][icu_pkg::CC_WORD] ? 16'h0002 : 16'h0001);
			end
		end
	end

	// Edge select and mask registers.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			edgeSel_r <= icu_pkg::RST_WORD;
			mask_r    <= icu_pkg::RST_BYTE;
		end else begin
			if (regWr && regAddr == icu_pkg::ADR_EDGE) begin
				edgeSel_r <= regWdata;
			end
			if (regWr && regAddr == icu_pkg::ADR_MASK) begin
				mask_r <= regWdata[7:0];
			end
		end
	end

	// sticky trap flags, write one to clear, set wins.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			trapFlag_r <= icu_pkg::RST_BYTE;
		end else begin
			trapFlag_r <= (trapFlag_r & ~((regWr && regAddr == icu_pkg::ADR_TRAP) ?
				regWdata[7:0] : 8'h00)) | 8'(hwTrap);
		end
	end

	// Count exhaustion events for software, write one to clear.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			status_r <= icu_pkg::RST_BYTE;
		end else begin
			status_r <= (status_r & ~((regWr && regAddr == icu_pkg::ADR_STAT) ?
				regWdata[7:0] : 8'h00)) |
				((goXfer && !winCont && winCnt == icu_pkg::CNT_ONE) ?
				8'h01 << winCh : 8'h00);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_r & mask_r);
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			trapPend_r <= icu_pkg::RST_BYTE;
			trapBusy_r <= 1'b0;
			trapCur_r  <= '0;
		end else begin
			trapPend_r <= (trapPend_r & ~(goTrap ? 8'h01 << trapIdx : 8'h00)) |
				8'(hwTrap);
			if (goTrap) begin
				trapBusy_r <= 1'b1;
				trapCur_r  <= trapIdx;
			end else if (trapDone) begin
				trapBusy_r <= 1'b0;
			end
		end
	end

	// software trap held until it can be issued.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			swPend_r <= 1'b0;
			swNum_r  <= icu_pkg::RST_BYTE;
		end else if (swTrap) begin
			swPend_r <= 1'b1;
			swNum_r  <= swTrapNum;
		end else if (swGo) begin
			swPend_r <= 1'b0;
		end
	end

	// push state and branch to vector.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cpuSvc <= '0;
		end else begin
			cpuSvc.valid  <= goTrap || swGo || goInt;
			cpuSvc.push   <= goTrap || swGo || goInt;
			if (goTrap) begin
				cpuSvc.vector <= icu_pkg::VEC_TRAP_BASE + 8'(trapIdx);
			end else if (swGo) begin
				cpuSvc.vector <= swNum_r;
			end else begin
				cpuSvc.vector <= icu_pkg::VEC_SRC_BASE + 8'(winIdx);
			end
		end
	end

	// one move, one cycle, nothing pushed.
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			xfer <= '0;
		end else begin
			xfer.valid <= goXfer;
			xfer.word  <= chnCtl_r[winCh][icu_pkg::CC_WORD];
			xfer.src   <= ptrSrc_r[winCh];
			xfer.dst   <= ptrDst_r[winCh];
		end
	end

	// Read back; unmapped words read as zero.
	always_comb begin
		rdNxt = 16'h0000;
		if (regAddr < icu_pkg::ADR_SRC + 8'(NSRC)) begin
			rdNxt = srcCtl_r[regAddr[SW-1:0]];
			rdNxt[icu_pkg::SC_REQ] = reqFlag_r[regAddr[SW-1:0]];
		end else if (regAddr[7:3] == icu_pkg::ADR_CHN[7:3]) begin
			rdNxt = {4'h0, chnCtl_r[regAddr[2:0]]};
		end else if (regAddr[7:3] == icu_pkg::ADR_SPTR[7:3]) begin
			rdNxt = ptrSrc_r[regAddr[2:0]];
		end else if (regAddr[7:3] == icu_pkg::ADR_DPTR[7:3]) begin
			rdNxt = ptrDst_r[regAddr[2:0]];
		end else if (regAddr == icu_pkg::ADR_EDGE) begin
			rdNxt = edgeSel_r;
		end else if (regAddr == icu_pkg::ADR_TRAP) begin
			rdNxt = {8'h00, trapFlag_r};
		end else if (regAddr == icu_pkg::ADR_STAT) begin
			rdNxt = {8'h00, status_r};
		end else if (regAddr == icu_pkg::ADR_MASK) begin
			rdNxt = {8'h00, mask_r};
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			regRdata <= 16'h0000;
		end else if (regRd) begin
			regRdata <= rdNxt;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	svc_excl_a: assert property (!(xfer.valid && cpuSvc.valid))
		else $error("Transfer and CPU service issued together.");
	int_issue_a: assert property (goInt |=> cpuSvc.valid && cpuSvc.push &&
		cpuSvc.vector == icu_pkg::VEC_SRC_BASE + 8'($past(winIdx)))
		else $error("Accepted interrupt not issued to its vector.");
	level_gate_a: assert property ((winFound && !blockStd && !goXfer &&
		winLvl <= cpuLevel) |=> !cpuSvc.valid)
		else $error("Interrupt issued at or below CPU level.");
	xfer_pulse_a: assert property (goXfer |=> xfer.valid && !cpuSvc.push
		##1 !xfer.valid || $past(goXfer))
		else $error("Transfer not started for one cycle.");
	count_dec_a: assert property ((goXfer && !winCont && !wrChn) |=>
		chnCtl_r[$past(winCh)][7:0] == $past(winCnt) - icu_pkg::CNT_ONE)
		else $error("Channel count not decremented by one.");
	zero_back_a: assert property ((winFound && !blockStd &&
		srcCtl_r[winIdx][icu_pkg::SC_XSEL] && winCnt == 8'h00 && !winCont &&
		winLvl > cpuLevel) |=> cpuSvc.valid && !xfer.valid)
		else $error("Exhausted channel did not fall back to interrupt.");
	trap_flag_a: assert property (hwTrap[0] |=> trapFlag_r[0])
		else $error("Hardware trap flag not set.");
	trap_block_a: assert property (trapBusy_r |=> !xfer.valid)
		else $error("Transfer issued during trap service.");
	lock_hold_a: assert property (lockSeq |=> !xfer.valid &&
		!(cpuSvc.valid && cpuSvc.vector >= icu_pkg::VEC_SRC_BASE &&
		!$past(swGo)))
		else $error("Service issued inside locked sequence.");
	req_clear_a: assert property (((goInt || goXfer) && !srcEvt[winIdx]) |=>
		!reqFlag_r[$past(winIdx)])
		else $error("Request flag not cleared on acceptance.");
	trap_take_a: assert property (goTrap |=> cpuSvc.valid &&
		cpuSvc.vector == icu_pkg::VEC_TRAP_BASE + 8'($past(trapIdx)))
		else $error("Hardware trap not issued to its vector.");
endmodule : interrupt_and_event_transfer

// ### cpu_core_model.sv
// Behavioural CPU core that takes services and returns from trap handlers.
`timescale 1ns/10ps

module cpu_core_model #(
	parameter int HOLD = 12
) (
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	// Services from the controller.
	input  wire icu_pkg::cpu_svc_s cpuSvc,
	// Level the program runs at outside handlers.
	input  wire logic [3:0]        baseLevel,
	// Status back to the controller.
	output logic [3:0]             cpuLevel,
	output logic                   trapDone
);
	logic [7:0] holdCnt_r;
	logic       inTrap_r;
	logic       inIsr_r;
	logic       isrNow;

	// The level rises in the acknowledge cycle itself, so an equal request
	// cannot slip in back to back. Hardware traps leave the level alone on purpose,
	// so that only the trap lockout can hold other requests off.
	assign isrNow = cpuSvc.valid && (cpuSvc.vector >= icu_pkg::VEC_SRC_BASE);
	assign cpuLevel = (inIsr_r || isrNow) ? 4'hF : baseLevel;

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			holdCnt_r <= 8'h00;
			inTrap_r  <= 1'b0;
			inIsr_r   <= 1'b0;
			trapDone  <= 1'b0;
		end else begin
			trapDone <= 1'b0;
			if (cpuSvc.valid) begin
				holdCnt_r <= HOLD[7:0];
				inTrap_r  <= inTrap_r | !isrNow;
				inIsr_r   <= inIsr_r | isrNow;
			end else if (holdCnt_r == 8'h01) begin
				holdCnt_r <= 8'h00;
				trapDone  <= inTrap_r;
				inTrap_r  <= 1'b0;
				inIsr_r   <= 1'b0;
			end else if (holdCnt_r != 8'h00) begin
				holdCnt_r <= holdCnt_r - 8'h01;
			end
		end
	end

endmodule : cpu_core_model

// ### interrupt_and_event_transfer_tb.sv
// Self-checking testbench of the interrupt and event transfer unit.
`timescale 1ns/10ps

module interrupt_and_event_transfer_tb;
	logic              clk_sys;
	logic              resetn;
	logic [7:0]        regAddr;
	logic [15:0]       regWdata;
	logic              regWr;
	logic              regRd;
	logic [15:0]       regRdata;
	logic [15:0]       periphReq;
	logic [3:0]        extPin;
	logic [3:0]        hwTrap;
	logic              swTrap;
	logic [7:0]        swTrapNum;
	logic [3:0]        cpuLevel;
	logic [3:0]        baseLevel;
	logic              lockSeq;
	logic              trapDone;
	logic              irq;
	icu_pkg::cpu_svc_s cpuSvc;
	icu_pkg::xfer_s    xfer;
	int                failures;
	int                totalChecks;
	int                cycles = 0;
	logic [7:0]        rstAdr [7];

	interrupt_and_event_transfer dut (.clk_sys, .resetn, .regAddr,
		.regWdata, .regWr, .regRd, .regRdata, .periphReq, .extPin, .hwTrap,
		.swTrap, .swTrapNum, .cpuLevel, .lockSeq, .trapDone, .cpuSvc,
		.xfer, .irq);

	cpu_core_model core (.clk_sys, .resetn, .cpuSvc, .baseLevel, .cpuLevel,
		.trapDone);

	always #5 clk_sys = ~clk_sys;

	task automatic conclude();
		$display("%0d checks, %0d mismatches", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude

	// A hung handshake must still reach the closing report.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			$display("[FAIL] cycle limit expected 20000 seen %0d", cycles);
			conclude();
		end
	end

	task automatic check(input string n, input logic [15:0] e,
		input logic [15:0] g);
		totalChecks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		regAddr  <= a;
		regWdata <= d;
		regWr    <= 1'b1;
		@(posedge clk_sys);
		regWr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [15:0] e,
		input string n);
		@(posedge clk_sys);
		regAddr <= a;
		regRd   <= 1'b1;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1;
		check(n, e, regRdata);
	endtask : rd

	task automatic pulse(input logic [15:0] req, input logic [3:0] trap);
		@(posedge clk_sys);
		periphReq <= req;
		hwTrap    <= trap;
		@(posedge clk_sys);
		periphReq <= 16'h0000;
		hwTrap    <= 4'h0;
	endtask : pulse

	task automatic wait_svc(input logic [7:0] vec);
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge clk_sys);
			#1;
			if (cpuSvc.valid === 1'b1) break;
		end
		check("cpuSvc", {6'h00, 2'b11, vec}, {6'h00, cpuSvc});
	endtask : wait_svc

	task automatic no_svc(input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk_sys);
			#1;
			check("cpuSvc.valid idle", 16'h0000, {15'h0000, cpuSvc.valid});
		end
	endtask : no_svc

	task automatic wait_xfer(input logic w, input logic [15:0] s,
		input logic [15:0] d);
		int i;
		for (i = 0; i < 30; i++) begin
			@(posedge clk_sys);
			#1;
			if (xfer.valid === 1'b1) break;
		end
		check("xfer flags", {14'h0000, 1'b1, w},
			{13'h0000, cpuSvc.valid, xfer.valid, xfer.word});
		check("xfer.src", s, xfer.src);
		check("xfer.dst", d, xfer.dst);
		@(posedge clk_sys);
		#1;
		check("xfer one cycle", 16'h0000, {15'h0000, xfer.valid});
	endtask : wait_xfer

	task automatic endtest(input string n);
		$display("test %s done, %0d mismatches so far", n, failures);
	endtask : endtest

	initial begin
		int m;
		clk_sys = 1'b0;
		resetn = 1'b0;
		regAddr = 8'h00;
		regWdata = 16'h0000;
		regWr = 1'b0;
		regRd = 1'b0;
		periphReq = 16'h0000;
		extPin = 4'h0;
		hwTrap = 4'h0;
		swTrap = 1'b0;
		swTrapNum = 8'h00;
		baseLevel = 4'h2;
		lockSeq = 1'b0;
		failures = 0;
		totalChecks = 0;
		rstAdr = '{icu_pkg::ADR_SRC, icu_pkg::ADR_CHN, icu_pkg::ADR_EDGE,
			icu_pkg::ADR_TRAP, icu_pkg::ADR_STAT, icu_pkg::ADR_MASK, 8'h50};
		repeat (10) @(posedge clk_sys);
		resetn <= 1'b1;
		@(posedge clk_sys);
		#1;
		check("outputs", 16'h0000, {13'h0000, cpuSvc.valid, xfer.valid, irq});
		foreach (rstAdr[k]) rd(rstAdr[k], 16'h0000, "reset value");
		endtest("reset");
		wr(icu_pkg::ADR_SRC + 8'h05, 16'h0013);
		pulse(16'h0020, 4'h0);
		wait_svc(8'h15);
		rd(icu_pkg::ADR_SRC + 8'h05, 16'h0013, "flag cleared");
		@(posedge clk_sys) baseLevel <= 4'h3;
		pulse(16'h0020, 4'h0);
		no_svc(20);
		rd(icu_pkg::ADR_SRC + 8'h05, 16'h0213, "flag pending");
		@(posedge clk_sys) baseLevel <= 4'h2;
		wait_svc(8'h15);
		wr(icu_pkg::ADR_SRC + 8'h02, 16'h0014);
		wr(icu_pkg::ADR_SRC + 8'h06, 16'h0017);
		pulse(16'h0044, 4'h0);
		wait_svc(8'h16);
		wait_svc(8'h12);
		endtest("priority");
		wr(icu_pkg::ADR_MASK, 16'h0004);
		wr(icu_pkg::ADR_SRC + 8'h03, 16'h00B6);
		wr(icu_pkg::ADR_CHN + 8'h02, 16'h0D02);
		wr(icu_pkg::ADR_SPTR + 8'h02, 16'h1000);
		wr(icu_pkg::ADR_DPTR + 8'h02, 16'h2000);
		pulse(16'h0008, 4'h0);
		wait_xfer(1'b1, 16'h1000, 16'h2000);
		rd(icu_pkg::ADR_CHN + 8'h02, 16'h0D01, "count");
		rd(icu_pkg::ADR_SPTR + 8'h02, 16'h1002, "src ptr");
		rd(icu_pkg::ADR_SRC + 8'h03, 16'h00B6, "flag moved");
		pulse(16'h0008, 4'h0);
		wait_xfer(1'b1, 16'h1002, 16'h2002);
		rd(icu_pkg::ADR_STAT, 16'h0004, "status");
		check("irq", 16'h0001, {15'h0000, irq});
		wr(icu_pkg::ADR_MASK, 16'h0000);
		repeat (2) @(posedge clk_sys);
		#1;
		check("irq masked", 16'h0000, {15'h0000, irq});
		pulse(16'h0008, 4'h0);
		wait_svc(8'h13);
		wr(icu_pkg::ADR_MASK, 16'h0004);
		wr(icu_pkg::ADR_STAT, 16'h0004);
		repeat (2) @(posedge clk_sys);
		#1;
		check("irq cleared", 16'h0000, {15'h0000, irq});
		wr(icu_pkg::ADR_SRC + 8'h04, 16'h0076);
		wr(icu_pkg::ADR_CHN + 8'h01, 16'h0605);
		wr(icu_pkg::ADR_SPTR + 8'h01, 16'h0100);
		wr(icu_pkg::ADR_DPTR + 8'h01, 16'h0200);
		pulse(16'h0010, 4'h0);
		wait_xfer(1'b0, 16'h0100, 16'h0200);
		rd(icu_pkg::ADR_CHN + 8'h01, 16'h0605, "cont count");
		rd(icu_pkg::ADR_SPTR + 8'h01, 16'h0101, "byte step");
		rd(icu_pkg::ADR_DPTR + 8'h01, 16'h0200, "fixed dst");
		endtest("transfer");
		wr(icu_pkg::ADR_SRC, 16'h0015);
		for (m = 1; m < 4; m++) begin
			wr(icu_pkg::ADR_EDGE, {14'h0000, m[1:0]});
			@(posedge clk_sys) extPin <= 4'h1;
			if (m[0]) wait_svc(8'h10); else no_svc(30);
			@(posedge clk_sys) extPin <= 4'h0;
			if (m[1]) wait_svc(8'h10); else no_svc(30);
		end
		// Let the last handler end so that only the trap lockout holds src 5.
		no_svc(14);
		endtest("edges");
		pulse(16'h0020, 4'h2);
		wait_svc(8'h01);
		rd(icu_pkg::ADR_TRAP, 16'h0002, "trap flag");
		pulse(16'h0000, 4'h5);
		wait_svc(8'h00);
		no_svc(8);
		wait_svc(8'h02);
		wait_svc(8'h15);
		rd(icu_pkg::ADR_TRAP, 16'h0007, "trap flags");
		wr(icu_pkg::ADR_TRAP, 16'h0007);
		rd(icu_pkg::ADR_TRAP, 16'h0000, "flags cleared");
		endtest("traps");
		@(posedge clk_sys) lockSeq <= 1'b1;
		@(posedge clk_sys);
		periphReq <= 16'h0020;
		swTrap    <= 1'b1;
		swTrapNum <= 8'h2A;
		hwTrap    <= 4'h1;
		@(posedge clk_sys);
		periphReq <= 16'h0000;
		swTrap    <= 1'b0;
		hwTrap    <= 4'h0;
		wait_svc(8'h2A);
		no_svc(20);
		@(posedge clk_sys) lockSeq <= 1'b0;
		wait_svc(8'h00);
		wait_svc(8'h15);
		endtest("lock");
		conclude();
	end

endmodule : interrupt_and_event_transfer_tb
